// *** common/ptc_pkg.sv ***
// Package for the power and timer control register block
// How it works
// - Baud double bit doubles serial rate, modes 1-3
// - View select makes serial top bit show framing error
// - Timer 1 overflow sets flag, vector clears, software writes
// - Timer 1 run bit is software owned, starts timer
// - Timer 0 overflow sets flag, vector clears, software writes
// - Timer 0 run bit is software owned, starts timer
// - Selected edge or level on pin sets irq1 flag
// - Irq1 vector clears flag only when edge triggered
// - Level mode irq1 flag follows inverted pin
// - Irq1 type bit selects edge or level trigger
// - Selected edge or level on pin sets irq0 flag
package ptc_pkg;
    // ------------------------------------------------------------
    // Register map (word index times four is the byte address)
    // ------------------------------------------------------------
    localparam logic [7:0] PTC_IDX_POWER   = 8'h87;
    localparam logic [7:0] PTC_IDX_TIMER   = 8'h88;
    localparam logic [7:0] PTC_IDX_SERIAL  = 8'h98;
    localparam logic [7:0] PTC_IDX_IRQ_ST  = 8'hF0;
    localparam logic [7:0] PTC_IDX_IRQ_MSK = 8'hF1;
    localparam logic [7:0] PTC_RST_POWER   = 8'h00;
    localparam logic [7:0] PTC_RST_TIMER   = 8'h00;
    localparam logic [7:0] PTC_RST_SERIAL  = 8'h00;
    localparam logic [7:0] PTC_RST_IRQ     = 8'h00;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PTC_B_BAUD_DBL = 7;
    localparam int PTC_B_FRAME_VIEW = 6;
    localparam int PTC_B_BROWNOUT = 5;
    localparam int PTC_B_UFLAG_HI = 3;
    localparam int PTC_B_UFLAG_LO = 2;
    localparam int PTC_B_PWR_DOWN = 1;
    localparam int PTC_B_IDLE     = 0;
    localparam int PTC_B_T1_OVF   = 7;
    localparam int PTC_B_T1_RUN   = 6;
    localparam int PTC_B_T0_OVF   = 5;
    localparam int PTC_B_T0_RUN   = 4;
    localparam int PTC_B_X1_FLAG  = 3;
    localparam int PTC_B_X1_TYPE  = 2;
    localparam int PTC_B_X0_FLAG  = 1;
    localparam int PTC_B_X0_TYPE  = 0;
    localparam int PTC_B_SER_MODE_LO = 7;
    localparam logic [7:0] PTC_POWER_WMASK = 8'hEF;
    // Interrupt status bits: t1 ovf, t0 ovf, irq1, irq0
    localparam int PTC_NIRQ = 4;

    typedef struct packed {
        logic       cyc;
        logic       stb;
        logic       we;
        logic [3:0] sel;
        logic [9:0] adr;
        logic [31:0] dat;
    } ptc_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } ptc_wb_rsp_t;

    typedef enum logic [1:0] {
        PTC_BUS_IDLE,
        PTC_BUS_ACK
    } ptc_bus_state_t;
endpackage : ptc_pkg

// *** hdl/ptc_regs.sv ***
// Power and timer/external interrupt control registers on classic Wishbone
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module ptc_regs import ptc_pkg::*; (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Wishbone slave
    input  wire ptc_wb_req_t wb_req,
    output ptc_wb_rsp_t      wb_rsp,
    // Core events
    input  wire logic        timer0_overflow,
    input  wire logic        timer1_overflow,
    input  wire logic        timer0_vector,
    input  wire logic        timer1_vector,
    input  wire logic        ext_irq0_vector,
    input  wire logic        ext_irq1_vector,
    input  wire logic        ext_irq0_pin_n,
    input  wire logic        ext_irq1_pin_n,
    input  wire logic        framing_error_flag,
    input  wire logic        brownout_event,
    // Control outputs
    output logic             baud_double,
    output logic             timer0_run,
    output logic             timer1_run,
    output logic             ext_irq0_flag,
    output logic             ext_irq1_flag,
    output logic             power_down_request,
    output logic             idle_request,
    output logic [7:0]       serial_control_view,
    output logic             irq
);
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic [7:0]     power_q, power_d;
    logic [7:0]     timer_q, timer_d;
    logic [7:0]     serial_q, serial_d;
    logic [3:0]     irq_st_q;
    logic [3:0]     irq_msk_q;
    ptc_bus_state_t bus_q;

    wire       req_new  = wb_req.cyc && wb_req.stb && (bus_q == PTC_BUS_IDLE);
    wire       wr_en    = req_new && wb_req.we && wb_req.sel[0];
    wire [7:0] idx      = wb_req.adr[9:2];
    wire [7:0] wdat     = wb_req.dat[7:0];
    wire       hit_pwr  = idx == PTC_IDX_POWER;
    wire       hit_tmr  = idx == PTC_IDX_TIMER;
    wire       hit_ser  = idx == PTC_IDX_SERIAL;
    wire       hit_st   = idx == PTC_IDX_IRQ_ST;
    wire       hit_msk  = idx == PTC_IDX_IRQ_MSK;
    wire       wr_pwr   = wr_en && hit_pwr;
    wire       wr_tmr   = wr_en && hit_tmr;
    wire       wr_ser   = wr_en && hit_ser;
    wire       wr_st    = wr_en && hit_st;
    wire       wr_msk   = wr_en && hit_msk;

    // Serial top bit shows the framing error when the view select is on
    wire [7:0] ser_view = power_q[PTC_B_FRAME_VIEW] ?
                          {framing_error_flag, serial_q[6:0]} : serial_q;
    wire [7:0] rd_sel   = hit_pwr ? power_q :
                          hit_tmr ? timer_q :
                          hit_ser ? ser_view :
                          hit_st  ? {4'h0, irq_st_q} :
                          hit_msk ? {4'h0, irq_msk_q} : 8'h00;

    // ------------------------------------------------------------
    // External interrupt detection
    // ------------------------------------------------------------
    logic xirq0_flag_d, xirq1_flag_d;
    logic xirq0_rise, xirq1_rise;

    ptc_ext_irq #(
        .PIN_IDLE (1'b1)
    ) ptc_ext_irq0_inst (
        .clk       (clk),
        .rstn      (rstn),
        .pin_n     (ext_irq0_pin_n),
        .edge_mode (timer_q[PTC_B_X0_TYPE]),
        .svc_entry (ext_irq0_vector),
        .flag_q    (timer_q[PTC_B_X0_FLAG]),
        .flag_d    (xirq0_flag_d),
        .flag_rise (xirq0_rise)
    );

    ptc_ext_irq #(
        .PIN_IDLE (1'b1)
    ) ptc_ext_irq1_inst (
        .clk       (clk),
        .rstn      (rstn),
        .pin_n     (ext_irq1_pin_n),
        .edge_mode (timer_q[PTC_B_X1_TYPE]),
        .svc_entry (ext_irq1_vector),
        .flag_q    (timer_q[PTC_B_X1_FLAG]),
        .flag_d    (xirq1_flag_d),
        .flag_rise (xirq1_rise)
    );

    // ------------------------------------------------------------
    // Timer overflow flags
    // ------------------------------------------------------------
    logic t0_ovf_d, t1_ovf_d;

    ptc_ovf_flag ptc_ovf_flag1_inst (
        .overflow  (timer1_overflow),
        .svc_entry (timer1_vector),
        .wr_en     (wr_tmr),
        .wr_bit    (wdat[PTC_B_T1_OVF]),
        .flag_q    (timer_q[PTC_B_T1_OVF]),
        .flag_d    (t1_ovf_d)
    );

    ptc_ovf_flag ptc_ovf_flag0_inst (
        .overflow  (timer0_overflow),
        .svc_entry (timer0_vector),
        .wr_en     (wr_tmr),
        .wr_bit    (wdat[PTC_B_T0_OVF]),
        .flag_q    (timer_q[PTC_B_T0_OVF]),
        .flag_d    (t0_ovf_d)
    );

    always_comb begin
        timer_d = timer_q;
        if (wr_tmr) begin
            timer_d[PTC_B_T1_RUN]  = wdat[PTC_B_T1_RUN];
            timer_d[PTC_B_T0_RUN]  = wdat[PTC_B_T0_RUN];
            timer_d[PTC_B_X1_TYPE] = wdat[PTC_B_X1_TYPE];
            timer_d[PTC_B_X0_TYPE] = wdat[PTC_B_X0_TYPE];
        end
        timer_d[PTC_B_T1_OVF]  = t1_ovf_d;
        timer_d[PTC_B_T0_OVF]  = t0_ovf_d;
        timer_d[PTC_B_X1_FLAG] = xirq1_flag_d;
        timer_d[PTC_B_X0_FLAG] = xirq0_flag_d;
    end

    always_comb begin
        power_d = power_q;
        if (wr_pwr) begin
            power_d = (wdat & PTC_POWER_WMASK) & ~(8'h01 << PTC_B_BROWNOUT);
            power_d[PTC_B_BROWNOUT] = power_q[PTC_B_BROWNOUT] && wdat[PTC_B_BROWNOUT];
        end
        if (brownout_event) begin
            power_d[PTC_B_BROWNOUT] = 1'b1;
        end
        serial_d = wr_ser ? wdat : serial_q;
    end

    // ------------------------------------------------------------
    // Interrupt status: write one to clear, new events win
    // ------------------------------------------------------------
    wire [3:0] irq_evt = {timer1_overflow, timer0_overflow, xirq1_rise, xirq0_rise};

    ptc_irq_ctrl #(
        .N (PTC_NIRQ)
    ) ptc_irq_ctrl_inst (
        .clk      (clk),
        .rstn     (rstn),
        .evt      (irq_evt),
        .wr_st    (wr_st),
        .wr_msk   (wr_msk),
        .wdat     (wdat[3:0]),
        .status_q (irq_st_q),
        .mask_q   (irq_msk_q),
        .irq      (irq)
    );

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            power_q  <= PTC_RST_POWER;
            timer_q  <= PTC_RST_TIMER;
            serial_q <= PTC_RST_SERIAL;
        end else begin
            power_q  <= power_d;
            timer_q  <= timer_d;
            serial_q <= serial_d;
        end
    end

    // One registered ack per request, one cycle after it, dropped the cycle after
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus_q      <= PTC_BUS_IDLE;
            wb_rsp.ack <= 1'b0;
            wb_rsp.dat <= 32'h0000_0000;
        end else begin
            case (bus_q)
                PTC_BUS_IDLE: begin
                    wb_rsp.ack <= req_new;
                    wb_rsp.dat <= req_new ? {24'h00_0000, rd_sel} : wb_rsp.dat;
                    bus_q      <= req_new ? PTC_BUS_ACK : PTC_BUS_IDLE;
                end
                PTC_BUS_ACK: begin
                    wb_rsp.ack <= 1'b0;
                    bus_q      <= PTC_BUS_IDLE;
                end
                default: begin
                    wb_rsp.ack <= 1'b0;
                    bus_q      <= PTC_BUS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign baud_double         = power_q[PTC_B_BAUD_DBL];
    assign power_down_request  = power_q[PTC_B_PWR_DOWN];
    assign idle_request        = power_q[PTC_B_IDLE];
    assign timer0_run          = timer_q[PTC_B_T0_RUN];
    assign timer1_run          = timer_q[PTC_B_T1_RUN];
    assign ext_irq0_flag       = timer_q[PTC_B_X0_FLAG];
    assign ext_irq1_flag       = timer_q[PTC_B_X1_FLAG];
    assign serial_control_view = ser_view;
endmodule : ptc_regs

// ------------------------------------------------------------
// One external interrupt input: edge latch or level follower
// ------------------------------------------------------------
module ptc_ext_irq import ptc_pkg::*; #(
    parameter logic PIN_IDLE = 1'b1
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Pin and controls
    input  wire logic pin_n,
    input  wire logic edge_mode,
    input  wire logic svc_entry,
    input  wire logic flag_q,
    // Next flag value and set event
    output logic      flag_d,
    output logic      flag_rise
);
    logic pin_q;

    // Falling edge seen as previous high, now low
    wire fall     = pin_q && !pin_n;
    // Edge mode latches until serviced; a new edge beats the clear
    wire edge_nxt = fall || (flag_q && !svc_entry);
    // Level mode keeps no memory, so the flag drops with the pin
    wire lvl_nxt  = !pin_n;

    assign flag_d    = edge_mode ? edge_nxt : lvl_nxt;
    assign flag_rise = flag_d && !flag_q;

    // Reset to the idle level so no false edge follows reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_q <= PIN_IDLE;
        end else begin
            pin_q <= pin_n;
        end
    end
endmodule : ptc_ext_irq

// ------------------------------------------------------------
// Timer overflow flag: hardware set beats every clear
// ------------------------------------------------------------
module ptc_ovf_flag import ptc_pkg::*; (
    // Events
    input  wire logic overflow,
    input  wire logic svc_entry,
    // Software write of the flag bit
    input  wire logic wr_en,
    input  wire logic wr_bit,
    // Flag
    input  wire logic flag_q,
    output logic      flag_d
);
    wire kept = flag_q && !svc_entry;
    wire base = wr_en ? wr_bit : kept;

    // An overflow in the clearing cycle must not be lost
    assign flag_d = overflow || base;
endmodule : ptc_ovf_flag

// ------------------------------------------------------------
// Sticky interrupt status with mask and level output
// ------------------------------------------------------------
module ptc_irq_ctrl import ptc_pkg::*; #(
    parameter int N = PTC_NIRQ
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // Events and register writes
    input  wire logic [N-1:0] evt,
    input  wire logic         wr_st,
    input  wire logic         wr_msk,
    input  wire logic [N-1:0] wdat,
    // Register contents and interrupt
    output logic [N-1:0]      status_q,
    output logic [N-1:0]      mask_q,
    output logic              irq
);
    logic [N-1:0] status_d;

    // Write one clears; an event in the same cycle wins
    always_comb begin
        status_d = status_q;
        if (wr_st) begin
            status_d = status_q & ~wdat;
        end
        status_d = status_d | evt;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status_q <= PTC_RST_IRQ[N-1:0];
            mask_q   <= PTC_RST_IRQ[N-1:0];
        end else begin
            status_q <= status_d;
            mask_q   <= wr_msk ? wdat : mask_q;
        end
    end

    assign irq = |(status_q & mask_q);
endmodule : ptc_irq_ctrl
`default_nettype wire

// *** tb/ptc_regs_asserts.sv ***
// Checker for the power and timer control register block
`timescale 1ns/1ns
`default_nettype none
module ptc_regs_asserts import ptc_pkg::*; (
    // Clock, reset and bus
    input wire logic        clk,
    input wire logic        rstn,
    input wire ptc_wb_req_t wb_req,
    input wire ptc_wb_rsp_t wb_rsp,
    // Pins and controls
    input wire logic        ext_irq0_pin_n,
    input wire logic        ext_irq1_pin_n,
    input wire logic        ext_irq0_flag,
    input wire logic        ext_irq1_flag,
    input wire logic        baud_double,
    input wire logic        timer0_run,
    input wire logic        timer1_run,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire logic req = wb_req.cyc && wb_req.stb;
    // Software bits may move only at the edge that completes a write
    wire logic wr = wb_rsp.ack && wb_req.we && wb_req.sel[0];
    ack_latency_a: assert property (req && !wb_rsp.ack |=> wb_rsp.ack) else $error("ack late");
    ack_pulse_a: assert property (wb_rsp.ack |=> !wb_rsp.ack) else $error("ack too long");
    ack_cause_a: assert property ($rose(wb_rsp.ack) |-> $past(req)) else $error("ack unasked");
    rdat_high_a: assert property (wb_rsp.ack |-> wb_rsp.dat[31:8] == 24'h0) else $error("upper data");
    baud_sw_a: assert property ($changed(baud_double) |-> wr) else $error("baud moved");
    t1_run_sw_a: assert property ($changed(timer1_run) |-> wr) else $error("run1 moved");
    t0_run_sw_a: assert property ($changed(timer0_run) |-> wr) else $error("run0 moved");
    irq1_set_a: assert property ($fell(ext_irq1_pin_n) |=> ext_irq1_flag) else $error("flag1");
    irq0_set_a: assert property ($fell(ext_irq0_pin_n) |=> ext_irq0_flag) else $error("flag0");
    ack_quiet_a: assert property (!req |=> !wb_rsp.ack) else $error("ack without request");
    rdat_hold_a: assert property (!wb_rsp.ack |-> $stable(wb_rsp.dat)) else $error("read data moved");
    cover property (irq);
    cover property (ext_irq1_flag && ext_irq1_pin_n);
    cover property (wr && timer1_run);
endmodule : ptc_regs_asserts
bind ptc_regs ptc_regs_asserts ptc_regs_asserts_inst (
    .clk(clk), .rstn(rstn), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .ext_irq0_pin_n(ext_irq0_pin_n), .ext_irq1_pin_n(ext_irq1_pin_n),
    .ext_irq0_flag(ext_irq0_flag), .ext_irq1_flag(ext_irq1_flag), .baud_double(baud_double),
    .timer0_run(timer0_run), .timer1_run(timer1_run), .irq(irq));
`default_nettype wire

// *** tb/tb_ptc_regs.sv ***
// Self-checking bench for the control register block
`timescale 1ns/1ns
`default_nettype none
module tb_ptc_regs import ptc_pkg::*;;
    localparam logic [9:0] PW = 10'h21C, TM = 10'h220, SR = 10'h260, ST = 10'h3C0, MK = 10'h3C4;
    logic        clk = 1'h0, rstn = 1'h0, frame_err = 1'h0, bo = 1'h0;
    ptc_wb_req_t req = '0;
    ptc_wb_rsp_t rsp;
    logic [5:0]  ev = 6'h0;
    logic [1:0]  pin_n = 2'h3, flg, run;
    logic        bd, pwr_dn, idle_rq, irq;
    logic [7:0]  scv, rd;
    int          error_cnt = 0, n_tests = 0, cyc_n = 0;
    ptc_regs ptc_regs_inst (.clk(clk), .rstn(rstn), .wb_req(req), .wb_rsp(rsp),
        .timer0_overflow(ev[0]), .timer1_overflow(ev[1]), .timer0_vector(ev[2]), .timer1_vector(ev[3]),
        .ext_irq0_vector(ev[4]), .ext_irq1_vector(ev[5]), .ext_irq0_pin_n(pin_n[0]), .ext_irq1_pin_n(pin_n[1]),
        .framing_error_flag(frame_err), .brownout_event(bo), .baud_double(bd), .timer0_run(run[0]),
        .timer1_run(run[1]), .ext_irq0_flag(flg[0]), .ext_irq1_flag(flg[1]), .power_down_request(pwr_dn),
        .idle_request(idle_rq), .serial_control_view(scv), .irq(irq));
    task chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask : chk
    task bus(input logic [9:0] a, input logic we, input logic [7:0] d, input logic [3:0] s);
        int i;
        @(posedge clk);
        req <= '{1'b1, 1'b1, we, s, a, {24'h0, d}};
        i = 0;
        // No local limit: the ack, or else the global timeout, ends this wait
        do begin
            @(posedge clk);
            i++;
        end while (rsp.ack !== 1'b1);
        rd = rsp.dat[7:0];
        chk(i == 2, "ack latency");
        req <= '0;
    endtask : bus
    task wr(input logic [9:0] a, input logic [7:0] d);
        bus(a, 1'b1, d, 4'hF);
        #1;
    endtask : wr
    task rdc(input logic [9:0] a, input logic [7:0] e);
        bus(a, 1'b0, 8'h00, 4'hF);
        chk(rd === e, "read data");
    endtask : rdc
    task pls(input int n);
        @(posedge clk);
        ev[n] <= 1'b1;
        @(posedge clk);
        ev[n] <= 1'b0;
        #1;
    endtask : pls
    task pin(input int i, input logic v);
        @(posedge clk);
        pin_n[i] <= v;
        repeat (2) @(posedge clk);
        #1;
    endtask : pin
    task t_reset;
        logic [9:0] a [6];
        a = '{PW, TM, SR, ST, MK, 10'h100};
        wr(10'h100, 8'hFF);
        foreach (a[k]) rdc(a[k], 8'h00);
    endtask : t_reset
    task t_rerst;
        wr(PW, 8'h8F);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        chk(bd === 1'b0 && pwr_dn === 1'b0 && idle_rq === 1'b0, "reset clears");
        rdc(PW, 8'h00);
        rdc(SR, 8'h00);
    endtask : t_rerst
    task t_power;
        bus(PW, 1'b1, 8'hC0, 4'hE);
        chk(bd === 1'b0, "sel ignored");
        wr(PW, 8'hC0);
        rdc(PW, 8'hC0);
        chk(bd === 1'b1, "baud set");
        frame_err <= 1'b1;
        @(posedge clk);
        #1;
        chk(scv[7] === 1'b1, "fe view");
        wr(PW, 8'h00);
        chk(scv[7] === 1'b0 && bd === 1'b0, "mode view");
        wr(SR, 8'h80);
        chk(scv[7] === 1'b1, "mode bit");
        // Brownout bit cannot be set by a write, bit 4 reads zero
        wr(PW, 8'h3F);
        rdc(PW, 8'h0F);
        chk(pwr_dn === 1'b1 && idle_rq === 1'b1, "power bits");
        @(posedge clk);
        bo <= 1'b1;
        @(posedge clk);
        bo <= 1'b0;
        rdc(PW, 8'h2F);
        wr(PW, 8'h0F);
        rdc(PW, 8'h0F);
        wr(PW, 8'h00);
        chk(pwr_dn === 1'b0 && idle_rq === 1'b0, "power clear");
    endtask : t_power
    task t_timer;
        wr(TM, 8'h50);
        chk(run === 2'h3, "runs on");
        pls(1);
        rdc(TM, 8'hD0);
        pls(3);
        rdc(TM, 8'h50);
        pls(0);
        rdc(TM, 8'h70);
        pls(2);
        rdc(TM, 8'h50);
        wr(TM, 8'hA0);
        rdc(TM, 8'hA0);
        chk(run === 2'h0, "runs off");
        wr(TM, 8'h00);
    endtask : t_timer
    task t_ext(input int i);
        wr(TM, 8'h01 << (2 * i));
        pin(i, 1'b0);
        chk(flg[i] === 1'b1, "edge set");
        pin(i, 1'b1);
        chk(flg[i] === 1'b1, "edge hold");
        pls(4 + i);
        chk(flg[i] === 1'b0, "edge clear");
        wr(TM, 8'h00);
        pin(i, 1'b0);
        chk(flg[i] === 1'b1, "level set");
        pls(4 + i);
        chk(flg[i] === 1'b1, "level kept");
        pin(i, 1'b1);
        chk(flg[i] === 1'b0, "level follow");
    endtask : t_ext
    task t_irq;
        rdc(ST, 8'h0F);
        chk(irq === 1'b0, "masked");
        wr(MK, 8'h08);
        chk(irq === 1'b1, "unmasked");
        wr(ST, 8'h08);
        chk(irq === 1'b0, "cleared");
        rdc(ST, 8'h07);
        wr(ST, 8'h07);
        rdc(ST, 8'h00);
    endtask : t_irq
    task results;
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    initial begin
        forever #4 clk = ~clk;
    end
    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 5000) begin
            error_cnt++;
            results;
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        t_reset;
        t_power;
        t_timer;
        t_ext(0);
        t_ext(1);
        t_irq;
        t_rerst;
        results;
    end
endmodule : tb_ptc_regs
`default_nettype wire
